/* src/scg_pkg.sv */
// package: constants and types of the sleep clock gating block
// assumes: one 20 MHz clock, core and peripherals outside
package scg_pkg;

   // ****************************************
   // widths, positions and counts
   // ****************************************
   localparam int unsigned TIMER_W = 24;
   localparam int unsigned PERIPH_N = 8;
   localparam logic [1:0] WAKE_HALT_CYC = 2'h3; // four cycles, counted 3..0
   localparam logic [TIMER_W-1:0] STANDBY_WAKE_CYC = 24'h000006;
   localparam logic [PERIPH_N-1:0] PERIPH_STOP_RESET = 8'h00;
   localparam int unsigned PS_ADC = 0;
   localparam int unsigned PS_RSVD = 4;
   localparam int unsigned PS_TIMER2 = 6;

   // ****************************************
   // modes and states
   // ****************************************
   typedef enum logic [2:0]
   {
      MODE_IDLE = 3'h0,
      MODE_ADC_NR = 3'h1,
      MODE_PWR_DOWN = 3'h2,
      MODE_PWR_SAVE = 3'h3,
      MODE_STANDBY = 3'h6
   } scg_mode_t;

   // gray along active, sleep, start-up, halt
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'h0,
      ST_SLEEP = 2'h1,
      ST_STARTUP = 2'h3,
      ST_HALT = 2'h2
   } scg_state_t;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed
   {
      logic reset_req;
      logic ext_a;
      logic ext_b;
      logic pin_change;
      logic twi_match;
      logic t2_ovf;
      logic t2_cmp;
      logic spm_ready;
      logic adc_done;
      logic wdt_irq;
      logic irq_any;
   } scg_wake_src_t;

   typedef struct packed
   {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic asy;
      logic main_osc;
      logic timer_osc;
      logic t2_sync;
   } scg_clk_en_t;

endpackage : scg_pkg

/* src/scg_wake_timer.sv */
// file: start-up delay down-counter for the wake path
// assumes: load is a one-cycle pulse on the same clock
`timescale 1ns/1ps

module scg_wake_timer
#(
   parameter int unsigned WIDTH = 24
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // control
   input wire logic load_in,
   input wire logic [WIDTH-1:0] load_val_in,
   // status
   output logic busy_out,
   output logic done_out
);

   logic [WIDTH-1:0] count_q;

   // counts load_val cycles, then one done pulse
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         count_q <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         done_out <= 1'b0;
         if (load_in)
         begin
            count_q <= load_val_in;
            busy_out <= 1'b1;
         end
         else if (busy_out)
         begin
            // a zero load ends like a load of one
            if (count_q <= WIDTH'(1))
            begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
            count_q <= count_q - WIDTH'(1);
         end
      end
   end

endmodule : scg_wake_timer

/* src/scg_sleep_ctrl.sv */
// file: sleep mode sequencer and clock gate controller
// assumes: wake sources arrive from other domains, core
// signals and fuse straps are on ref_clk_in
`timescale 1ns/1ps

module scg_sleep_ctrl
#(
   // start-up delays chosen by the clock source fuses
   parameter logic [scg_pkg::TIMER_W-1:0] STARTUP_CYC_0 = 24'h000400,
   parameter logic [scg_pkg::TIMER_W-1:0] STARTUP_CYC_1 = 24'h004000,
   parameter logic [scg_pkg::TIMER_W-1:0] STARTUP_CYC_2 = 24'h010000,
   parameter logic [scg_pkg::TIMER_W-1:0] STARTUP_CYC_3 = 24'h020000
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // core side
   input wire logic sleep_permit_in,
   input wire logic [2:0] sleep_mode_select_in,
   input wire logic sleep_instr_in,
   input wire logic global_irq_en_in,
   input wire logic [1:0] timer2_irq_mask_in,
   input wire logic [3:0] clock_source_select_fuses_in,
   input wire logic crystal_option_in,
   // peripheral configuration
   input wire logic adc_enable_in,
   input wire logic timer2_enable_in,
   input wire logic timer2_async_in,
   input wire logic [1:0] ext_level_sense_in,
   input wire logic [scg_pkg::PERIPH_N-1:0] peripheral_clock_stop_register_in,
   // wake sources, asynchronous
   input wire scg_pkg::scg_wake_src_t wake_src_in,
   // clock gates
   output scg_pkg::scg_clk_en_t clk_gate_out,
   output logic [scg_pkg::PERIPH_N-1:0] periph_clk_en_out,
   output logic [scg_pkg::PERIPH_N-1:0] periph_access_en_out,
   // core control
   output logic core_stall_out,
   output logic irq_service_out,
   output logic reset_wake_out,
   output logic adc_start_out,
   output logic sleeping_out,
   output logic [2:0] sleep_mode_out
);

   import scg_pkg::*;

   // ****************************************
   // decoding functions
   // ****************************************

   // legal codes only; standby also needs a crystal
   function automatic logic mode_legal(input logic [2:0] sel, input logic xtal);
      logic ok;
      ok = 1'b0;
      case (sel)
         3'h0, 3'h1, 3'h2, 3'h3: ok = 1'b1;
         3'h6: ok = xtal;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : mode_legal

   // clock gates held while asleep in a mode
   function automatic scg_clk_en_t sleep_clocks(input scg_mode_t m, input logic t2_en,
                                                input logic t2_async);
      scg_clk_en_t c;
      c = '0;
      unique case (m)
         MODE_IDLE:
         begin
            c.io = 1'b1;
            c.adc = 1'b1;
            c.asy = 1'b1;
            c.main_osc = 1'b1;
            c.timer_osc = t2_async;
            c.t2_sync = 1'b1;
         end
         MODE_ADC_NR:
         begin
            c.adc = 1'b1;
            c.asy = 1'b1;
            c.main_osc = 1'b1;
            c.timer_osc = t2_async;
            c.t2_sync = 1'b1;
         end
         MODE_PWR_SAVE:
         begin
            c.asy = t2_en;
            c.timer_osc = t2_en & t2_async;
            c.main_osc = t2_en & ~t2_async;
            c.t2_sync = t2_en & ~t2_async;
         end
         MODE_STANDBY:
            c.main_osc = 1'b1;
         MODE_PWR_DOWN:
            c = '0;
      endcase
      return c;
   endfunction : sleep_clocks

   // ****************************************
   // wake source synchroniser
   // ****************************************
   scg_wake_src_t wake_meta_q;
   scg_wake_src_t wake_q;

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         wake_meta_q <= '0;
         wake_q <= '0;
      end
      else if (clk_en_in)
      begin
         wake_meta_q <= wake_src_in;
         wake_q <= wake_meta_q;
      end
   end

   // ****************************************
   // wake qualification
   // ****************************************
   scg_state_t state_q;
   scg_mode_t mode_q;
   logic [1:0] halt_cnt_q;
   logic ext_level;
   logic t2_wake;
   logic deep_wake;
   logic wake_ok;
   logic enter_sleep;
   logic need_startup;
   logic [TIMER_W-1:0] startup_val;
   logic timer_busy;
   logic timer_done;

   // edge-sensed external pins never end deep sleep
   assign ext_level = (wake_q.ext_a & ext_level_sense_in[0]) |
                      (wake_q.ext_b & ext_level_sense_in[1]);
   // timer2 wake needs its mask bit and global enable
   assign t2_wake = global_irq_en_in & timer2_enable_in &
                    ((wake_q.t2_ovf & timer2_irq_mask_in[0]) |
                     (wake_q.t2_cmp & timer2_irq_mask_in[1]));
   // common set of power-down wake sources
   assign deep_wake = wake_q.reset_req | wake_q.wdt_irq | wake_q.twi_match |
                      ext_level | wake_q.pin_change;

   always_comb
   begin
      wake_ok = 1'b0;
      unique case (mode_q)
         MODE_IDLE:
            wake_ok = wake_q.irq_any | wake_q.reset_req;
         MODE_ADC_NR:
            wake_ok = deep_wake | wake_q.adc_done | wake_q.spm_ready |
                      t2_wake;
         MODE_PWR_SAVE:
            wake_ok = deep_wake | t2_wake;
         MODE_PWR_DOWN, MODE_STANDBY:
            wake_ok = deep_wake;
      endcase
   end

   // ****************************************
   // entry and start-up selection
   // ****************************************

   // reserved codes simply leave the core running
   assign enter_sleep = (state_q == ST_ACTIVE) & sleep_instr_in & sleep_permit_in &
                        mode_legal(sleep_mode_select_in, crystal_option_in);
   // only power-down, power-save and standby wait for a start-up
   assign need_startup = (mode_q == MODE_PWR_DOWN) | (mode_q == MODE_PWR_SAVE) |
                         (mode_q == MODE_STANDBY);

   // start-up delay follows the clock source select fuses; standby uses its fixed count
   always_comb
   begin
      startup_val = STARTUP_CYC_0;
      if (mode_q == MODE_STANDBY)
         startup_val = STANDBY_WAKE_CYC;
      else
      begin
         unique case (clock_source_select_fuses_in[1:0])
            2'h0: startup_val = STARTUP_CYC_0;
            2'h1: startup_val = STARTUP_CYC_1;
            2'h2: startup_val = STARTUP_CYC_2;
            2'h3: startup_val = STARTUP_CYC_3;
         endcase
      end
   end

   scg_wake_timer #(.WIDTH(TIMER_W)) u_wake_timer
   (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .load_in((state_q == ST_SLEEP) & wake_ok & ~wake_q.reset_req & need_startup),
      // done is registered, so load one short to keep the start-up phase at exactly N cycles
      .load_val_in(startup_val - TIMER_W'(1)),
      .busy_out(timer_busy),
      .done_out(timer_done)
   );

   // ****************************************
   // sleep sequencer
   // ****************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         state_q <= ST_ACTIVE;
         mode_q <= MODE_IDLE;
         halt_cnt_q <= 2'h0;
      end
      else if (clk_en_in)
      begin
         unique case (state_q)
            ST_ACTIVE:
               if (enter_sleep)
               begin
                  state_q <= ST_SLEEP;
                  mode_q <= scg_mode_t'(sleep_mode_select_in);
               end
            ST_SLEEP:
               if (wake_q.reset_req)
                  state_q <= ST_ACTIVE; // reset vector takes over
               else if (wake_ok & need_startup)
                  state_q <= ST_STARTUP;
               else if (wake_ok)
               begin
                  state_q <= ST_HALT;
                  halt_cnt_q <= WAKE_HALT_CYC;
               end
            ST_STARTUP:
               if (timer_done)
               begin
                  state_q <= ST_HALT;
                  halt_cnt_q <= WAKE_HALT_CYC;
               end
            ST_HALT:
               if (halt_cnt_q == 2'h0)
                  state_q <= ST_ACTIVE;
               else
                  halt_cnt_q <= halt_cnt_q - 2'h1;
         endcase
      end
   end

   // ****************************************
   // clock gates
   // ****************************************
   scg_clk_en_t clk_gate_d;
   logic [PERIPH_N-1:0] periph_en_d;

   always_comb
   begin
      clk_gate_d = '1;
      clk_gate_d.timer_osc = timer2_async_in;
      unique case (state_q)
         ST_SLEEP:
            clk_gate_d = sleep_clocks(mode_q, timer2_enable_in, timer2_async_in);
         ST_STARTUP:
         begin
            // only main_osc, and timer_osc for asynchronous timer2, runs while it settles
            clk_gate_d = '0;
            clk_gate_d.main_osc = 1'b1;
            clk_gate_d.timer_osc = timer2_async_in;
         end
         ST_ACTIVE, ST_HALT:
            clk_gate_d.cpu = 1'b1;
      endcase
   end

   // deep modes gate io, so io stop bits only matter awake or idle; adc and sync timer2 bits also matter in modes keeping those clocks
   for (genvar i = 0; i < PERIPH_N; i++)
   begin : g_periph
      if (i == PS_RSVD)
      begin : g_rsvd
         assign periph_en_d[i] = 1'b0;
      end
      else if (i == PS_ADC)
      begin : g_adc
         assign periph_en_d[i] = clk_gate_d.adc & ~peripheral_clock_stop_register_in[i];
      end
      else if (i == PS_TIMER2)
      begin : g_t2
         // asynchronous timer2 ignores the stop bit
         assign periph_en_d[i] = timer2_async_in ? clk_gate_d.asy :
                                 (clk_gate_d.t2_sync & ~peripheral_clock_stop_register_in[i]);
      end
      else
      begin : g_io
         assign periph_en_d[i] = clk_gate_d.io & ~peripheral_clock_stop_register_in[i];
      end
   end

   // stopped clock freezes state, so clearing the bit resumes it
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         clk_gate_out <= '1;
         periph_clk_en_out <= ~PERIPH_STOP_RESET;
         periph_access_en_out <= ~PERIPH_STOP_RESET;
      end
      else if (clk_en_in)
      begin
         clk_gate_out <= clk_gate_d;
         periph_clk_en_out <= periph_en_d;
         periph_access_en_out <= ~peripheral_clock_stop_register_in;
      end
   end

   // ****************************************
   // core control pulses and levels
   // ****************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         core_stall_out <= 1'b0;
         irq_service_out <= 1'b0;
         reset_wake_out <= 1'b0;
         adc_start_out <= 1'b0;
         sleeping_out <= 1'b0;
         sleep_mode_out <= 3'h0;
      end
      else if (clk_en_in)
      begin
         core_stall_out <= (state_q != ST_ACTIVE) | enter_sleep;
         irq_service_out <= (state_q == ST_HALT) & (halt_cnt_q == 2'h0);
         reset_wake_out <= (state_q == ST_SLEEP) & wake_q.reset_req;
         // conversion starts on entry to idle or noise reduction, one cycle before the sleep clock gates
         adc_start_out <= enter_sleep & adc_enable_in &
                          (sleep_mode_select_in[2:1] == 2'h0);
         sleeping_out <= (state_q == ST_SLEEP);
         sleep_mode_out <= mode_q;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_halt_entry;
      $changed(state_q) && (state_q == ST_HALT);
   endsequence

   sequence s_asleep(scg_mode_t m);
      (state_q == ST_SLEEP) && (mode_q == m) && clk_en_in;
   endsequence

   a_sleep_permit: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (state_q == ST_ACTIVE) && !sleep_permit_in && clk_en_in |=> state_q == ST_ACTIVE)
      else $error("sleep entered without permit");

   a_halt_four: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_halt_entry ##0 clk_en_in [*4] |=> (state_q == ST_ACTIVE) && irq_service_out)
      else $error("wake halt not four cycles");

   a_idle_clocks: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_asleep(MODE_IDLE) |=> !clk_gate_out.cpu && !clk_gate_out.flash && clk_gate_out.io)
      else $error("idle clock gates wrong");

   a_adc_start: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      enter_sleep && adc_enable_in && clk_en_in && (sleep_mode_select_in == 3'h1)
      |=> adc_start_out ##1 !adc_start_out)
      else $error("no conversion start on entry");

   a_adcnr_clocks: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_asleep(MODE_ADC_NR) |=> !clk_gate_out.io && clk_gate_out.adc)
      else $error("adc mode clock gates wrong");

   a_pd_clocks: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_asleep(MODE_PWR_DOWN) |=> (clk_gate_out == '0) && (periph_clk_en_out == '0))
      else $error("power-down left a clock running");

   a_edge_no_wake: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_asleep(MODE_PWR_DOWN) && ((wake_q & 11'h5fe) == 11'h000) && !ext_level_sense_in[0]
      |=> state_q == ST_SLEEP)
      else $error("edge interrupt woke deep sleep");

   a_standby_six: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      s_asleep(MODE_STANDBY) && wake_ok && !wake_q.reset_req
      |=> (state_q == ST_STARTUP) && clk_gate_out.main_osc ##6 state_q == ST_HALT)
      else $error("standby wake not six cycles");

   a_stop_access: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      peripheral_clock_stop_register_in[7] && clk_en_in
      |=> !periph_clk_en_out[7] && !periph_access_en_out[7])
      else $error("stopped peripheral still clocked");

   a_reserved_mode: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (state_q == ST_ACTIVE) && clk_en_in && sleep_instr_in && sleep_mode_select_in[2] &&
      (sleep_mode_select_in != 3'h6) |=> state_q == ST_ACTIVE)
      else $error("reserved mode entered sleep");

endmodule : scg_sleep_ctrl

/* verif/scg_far_side.sv */
// partner model: wake sources and converter facing the sleep controller
// assumes: bench raises sources by one-cycle pulses on ref_clk_in
`timescale 1ns/1ps

module scg_far_side
#(
   parameter int unsigned ADC_CYC = 5
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // bench side
   input wire scg_pkg::scg_wake_src_t raise_in,
   input wire logic clear_in,
   // controller side
   input wire logic adc_start_in,
   input wire logic irq_service_in,
   input wire logic reset_wake_in,
   output scg_pkg::scg_wake_src_t wake_src_out
);
   import scg_pkg::*;

   // ****************************************
   // converter and source levels
   // ****************************************
   logic [3:0] adc_cnt_q;

   // conversion time after a start request
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         adc_cnt_q <= 4'h0;
      else if (adc_start_in)
         adc_cnt_q <= 4'(ADC_CYC);
      else if (adc_cnt_q != 4'h0)
         adc_cnt_q <= adc_cnt_q - 4'h1;
   end

   // levels stay up until the core is served, a reset wake or clear_in; a raise in that same cycle is dropped
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in || clear_in || irq_service_in || reset_wake_in)
         wake_src_out <= '0;
      else
      begin
         wake_src_out <= wake_src_out | raise_in;
         if (adc_cnt_q == 4'h1)
            wake_src_out.adc_done <= 1'b1;
      end
   end

endmodule : scg_far_side

/* verif/scg_sleep_ctrl_tb_top.sv */
// bench: directed sleep entry, wake and clock stop sequences
// assumes: controller and far-side model share ref_clk_in at 20 MHz
`timescale 1ns/1ps

module scg_sleep_ctrl_tb_top;
   import scg_pkg::*;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic permit = 1'b0;
   logic [2:0] mode_sel = 3'h0;
   logic instr = 1'b0;
   logic gie = 1'b1;
   logic [1:0] t2_mask = 2'h0;
   logic [3:0] fuses = 4'h2;
   logic crystal = 1'b1;
   logic adc_en = 1'b0;
   logic t2_en = 1'b1;
   logic t2_async = 1'b1;
   logic [1:0] level_sense = 2'h0;
   logic [7:0] stop = 8'h00;
   logic clear = 1'b0;
   scg_wake_src_t raise = '0;
   scg_wake_src_t wake_src;
   scg_clk_en_t gates;
   logic [7:0] pclk_en;
   logic [7:0] pacc_en;
   logic stall, irq_srv, rst_wake, adc_start, sleeping, adc_seen, woke_rst;
   logic [2:0] mode_out;
   logic [2:0] bad [5] = '{3'h0, 3'h4, 3'h5, 3'h7, 3'h6};
   logic [2:0] deep [4] = '{3'h1, 3'h2, 3'h3, 3'h6};
   logic [7:0] deep_g [4] = '{8'h03, 8'h00, 8'h00, 8'h01};
   int miscompares = 0;
   int num_checks = 0;

   // 50 ns period
   initial
   begin
      forever #25 ref_clk_in = ~ref_clk_in;
   end

   // short start-up delays keep the run brief; fuse code 2 selects 60 cycles
   scg_sleep_ctrl #(.STARTUP_CYC_0(24'h000008), .STARTUP_CYC_1(24'h00001e), .STARTUP_CYC_2(24'h00003c),
      .STARTUP_CYC_3(24'h00005a))
   DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(1'b1), .sleep_permit_in(permit),
      .sleep_mode_select_in(mode_sel), .sleep_instr_in(instr), .global_irq_en_in(gie),
      .timer2_irq_mask_in(t2_mask), .clock_source_select_fuses_in(fuses), .crystal_option_in(crystal),
      .adc_enable_in(adc_en), .timer2_enable_in(t2_en), .timer2_async_in(t2_async),
      .ext_level_sense_in(level_sense), .peripheral_clock_stop_register_in(stop), .wake_src_in(wake_src),
      .clk_gate_out(gates), .periph_clk_en_out(pclk_en), .periph_access_en_out(pacc_en),
      .core_stall_out(stall), .irq_service_out(irq_srv), .reset_wake_out(rst_wake),
      .adc_start_out(adc_start), .sleeping_out(sleeping), .sleep_mode_out(mode_out));

   scg_far_side FAR (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .raise_in(raise), .clear_in(clear),
      .adc_start_in(adc_start), .irq_service_in(irq_srv), .reset_wake_in(rst_wake), .wake_src_out(wake_src));

   // ****************************************
   // compare and access tasks
   // ****************************************
   function automatic logic [7:0] g5(input scg_clk_en_t g);
      return {3'h0, g.cpu, g.flash, g.io, g.adc, g.main_osc};
   endfunction : g5

   task automatic end_of_test();
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_range(input string what, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_range

   // sleep instruction with permit bit; returns two cycles after the taking edge
   task automatic enter(input logic [2:0] mode, input logic en);
      mode_sel <= mode;
      permit <= en;
      instr <= 1'b1;
      @(posedge ref_clk_in);
      instr <= 1'b0;
      #1;
      // the start pulse stands only in the cycle after the taking edge
      adc_seen = adc_start;
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask : enter

   // raise a source and count cycles until the controller answers
   task automatic wake(input scg_wake_src_t src, input int lo, input int hi);
      int lat;
      lat = 0;
      raise <= src;
      @(posedge ref_clk_in);
      raise <= '0;
      #1;
      while (irq_srv !== 1'b1 && rst_wake !== 1'b1)
      begin
         @(posedge ref_clk_in);
         #1;
         lat++;
         if (lat > 300)
         begin
            miscompares++;
            end_of_test();
         end
      end
      woke_rst = rst_wake;
      if (woke_rst !== 1'b1)
         chk_range("wake latency", lo, hi, lat);
      @(posedge ref_clk_in);
      #1;
      if (woke_rst !== 1'b1)
         chk("stall after service", 8'h00, {7'h0, stall});
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("awake", 8'h00, {7'h0, sleeping});
   endtask : wake

   // a source that must not end sleep; it is withdrawn afterwards
   task automatic nowake(input scg_wake_src_t src);
      raise <= src;
      @(posedge ref_clk_in);
      raise <= '0;
      repeat (15) @(posedge ref_clk_in);
      #1;
      chk("still asleep", 8'h01, {7'h0, sleeping});
      clear <= 1'b1;
      @(posedge ref_clk_in);
      clear <= 1'b0;
      // let the two-flop synchroniser drain so a stale level cannot wake later
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask : nowake

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (2) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1;
      chk("gates after reset", 8'hff, gates);
      stop <= 8'hac;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("periph clk", 8'h43, pclk_en);
      chk("periph access", 8'h53, pacc_en);
      // idle keeps io clocks and stop bits, wakes on any interrupt
      adc_en <= 1'b1;
      enter(3'h0, 1'b1);
      chk("adc start", 8'h01, {7'h0, adc_seen});
      chk("idle gates", 8'h07, g5(gates));
      chk("sleeping", 8'h01, {7'h0, sleeping});
      chk("idle periph clk", 8'h43, pclk_en);
      repeat (10) @(posedge ref_clk_in);
      wake(11'h001, 6, 12);
      stop <= 8'h00;
      adc_en <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("periph restart", 8'hef, pclk_en);
      // no permit, reserved codes and standby without crystal do nothing
      foreach (bad[i])
      begin
         crystal <= (bad[i] != 3'h6);
         enter(bad[i], i != 0);
         chk("refused sleep", 8'h00, {7'h0, sleeping | stall});
      end
      crystal <= 1'b1;
      // deep modes: gates, edge pins ignored, reset request ends sleep
      foreach (deep[i])
      begin
         enter(deep[i], 1'b1);
         chk("deep gates", deep_g[i], g5(gates));
         chk("mode out", {5'h0, deep[i]}, {5'h0, mode_out});
         nowake(11'h201);
         wake(11'h400, 2, 8);
         chk("reset wake", 8'h01, {7'h0, woke_rst});
      end
      // conversion complete ends noise reduction sleep
      adc_en <= 1'b1;
      enter(3'h1, 1'b1);
      adc_en <= 1'b0;
      wake(11'h000, 4, 20);
      // level pin b from power-down waits for the selected start-up
      level_sense <= 2'h2;
      enter(3'h2, 1'b1);
      wake(11'h100, 64, 74);
      // timer2 needs its mask in power-save; synchronous timer2 keeps the main source
      t2_async <= 1'b0;
      enter(3'h3, 1'b1);
      chk("ps sync gates", 8'h01, g5(gates));
      nowake(11'h020);
      t2_mask <= 2'h1;
      wake(11'h020, 64, 74);
      // standby restarts quickly
      enter(3'h6, 1'b1);
      wake(11'h040, 12, 18);
      end_of_test();
   end

endmodule : scg_sleep_ctrl_tb_top
